// ### testbench/bitstream_decrypt_security_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module bitstream_decrypt_security_control_test;
  typedef struct {
    logic [3:0] wa;
    logic [31:0] wd;
    logic [3:0] ra;
    logic [31:0] exp;
  } row_t;
  localparam int PROG = 0, RECONF = 1, KLOAD = 2, KEXIT = 3, KWR = 4, LEND = 5, MISM = 6, KRD = 7;
  localparam logic [3:0] CT = sec_ctrl_pkg::CTRL_OFFS;
  localparam logic [3:0] ST = sec_ctrl_pkg::STATUS_OFFS;
  // host has locked fuse key; word fixed
  localparam logic [31:0] FUSE = 32'h3c5a_9617;
  row_t rows [4] = '{'{4'h0, 32'h3, 4'h0, 32'h3}, '{4'h8, 32'hffff_ffff, 4'h0, 32'h3},
    '{4'h0, 32'h6, 4'h8, 32'h0}, '{4'h0, 32'ha, 4'h0, 32'h2}};
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] ev = 8'h0;
  logic [3:0] reg_addr_in = 4'h0;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, rb_req_in = 1'b0, pr_req_in = 1'b0, send = 1'b0;
  logic [2:0] jtag_key_idx_in = 3'h0;
  logic [31:0] reg_wdata_in = 32'h0, jtag_key_wdata_in = 32'h0, ctl = 32'h0, rdv, rdata, dec_word;
  sec_ctrl_pkg::cfg_src_t rb_src_in = sec_ctrl_pkg::SRC_SERIAL;
  sec_ctrl_pkg::cfg_src_t pr_src_in = sec_ctrl_pkg::SRC_SERIAL;
  sec_ctrl_pkg::cfg_src_t src;
  sec_ctrl_pkg::cfg_word_t cfg_w;
  sec_ctrl_pkg::load_word_t load_w;
  logic cfg_clear, key_sel, exp_clr, rb_gnt, pr_gnt, mon_ok, fuse_ok, done, init, init_oe, busy, seen;
  int failures = 0, check_count = 0, words = 0;
  sec_ctrl uut (
    .mclk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out(rdata), .program_in(ev[PROG]), .jtag_reconfig_instruction_in(ev[RECONF]),
    .internal_reprogram_cmd_in(1'b0), .key_load_instruction_in(ev[KLOAD]),
    .key_access_exit_in(ev[KEXIT]), .jtag_key_wr_in(ev[KWR]), .jtag_key_idx_in,
    .jtag_key_wdata_in, .cfg_in(cfg_w), .load_end_in(ev[LEND]), .mismatch_in(ev[MISM]),
    .load_out(load_w), .cfg_clear_out(cfg_clear), .dec_key_rd_in(ev[KRD]),
    .dec_key_idx_in(jtag_key_idx_in), .fuse_key_word_in(FUSE), .dec_key_word_out(dec_word),
    .dec_key_sel_out(key_sel), .expkey_clear_out(exp_clr), .rb_req_in, .rb_src_in, .pr_req_in,
    .pr_src_in, .rb_grant_out(rb_gnt), .pr_grant_out(pr_gnt), .monitor_rb_ok_out(mon_ok),
    .fuse_prog_ok_out(fuse_ok), .done_out(done), .init_out(init), .init_oe_out(init_oe)
  );
  cfg_source src_i (.mclk_in, .rst_in, .send_in(send), .ctl_in(ctl), .src_in(src),
    .cfg_out(cfg_w), .busy_out(busy));
  always #4 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (load_w.valid === 1'b1) words++;
  // ----------------
  // Tasks
  // ----------------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic chk(input string name, input logic [31:0] seen_v, input logic [31:0] exp);
    check_count++;
    if (seen_v !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen_v);
    end
  endtask
  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    tick(1);
    ev[b] <= 1'b0;
    tick(1);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    tick(1);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    tick(1);
    reg_rd_in <= 1'b0;
    tick(1);
    rdv = rdata;
  endtask
  task automatic go(input logic [31:0] c, input sec_ctrl_pkg::cfg_src_t s);
    ctl <= c;
    src <= s;
    words = 0;
    send <= 1'b1;
    tick(1);
    send <= 1'b0;
  endtask
  task automatic load(input logic [31:0] c, input sec_ctrl_pkg::cfg_src_t s, input logic fin);
    go(c, s);
    tick(1);
    for (int i = 0; i < 40 && busy; i++) tick(1);
    tick(2);
    if (fin) pulse(LEND);
    tick(1);
  endtask
  task automatic req(input sec_ctrl_pkg::cfg_src_t s, input logic rb_exp, input logic pr_exp);
    rb_src_in <= s;
    pr_src_in <= s;
    rb_req_in <= 1'b1;
    pr_req_in <= 1'b1;
    tick(1);
    chk("rb_grant", 32'(rb_gnt), 32'(rb_exp));
    chk("pr_grant", 32'(pr_gnt), 32'(pr_exp));
    rb_req_in <= 1'b0;
    pr_req_in <= 1'b0;
    tick(1);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----------------
  // Sequence
  // ----------------
  initial begin
    src = sec_ctrl_pkg::SRC_SERIAL;
    tick(2);
    chk("rst_done", 32'(done), 32'h0);
    chk("rst_init_oe", 32'(init_oe), 32'h1);
    chk("rst_clear", 32'(cfg_clear), 32'h1);
    tick(4);
    rst_in <= 1'b0;
    tick(2);
    for (int i = 0; i < 4; i++) begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra);
      chk("reg_row", rdv, rows[i].exp);
    end
    load(32'h0, sec_ctrl_pkg::SRC_SERIAL, 1'b1);
    chk("plain_words", 32'(words), 32'd11);
    chk("plain_done", 32'(done), 32'h1);
    req(sec_ctrl_pkg::SRC_SERIAL, 1'b1, 1'b1);
    req(sec_ctrl_pkg::SRC_INTERNAL, 1'b1, 1'b1);
    wr(CT, 32'h4);
    req(sec_ctrl_pkg::SRC_JTAG, 1'b0, 1'b0);
    load(32'h0, sec_ctrl_pkg::SRC_SERIAL, 1'b0);
    chk("relaunch_words", 32'(words), 32'h0);
    chk("relaunch_done", 32'(done), 32'h1);
    pulse(KLOAD);
    for (int i = 0; i < 8; i++) begin
      jtag_key_idx_in <= 3'(i);
      jtag_key_wdata_in <= 32'ha500_0000 | 32'(i);
      pulse(KWR);
    end
    pulse(KEXIT);
    rd(ST);
    chk("key_valid", 32'(rdv[4]), 32'h1);
    chk("key_erase_done", 32'(done), 32'h0);
    wr(CT, 32'h2);
    load(32'h40, sec_ctrl_pkg::SRC_X8, 1'b1);
    rd(ST);
    chk("enc_done", 32'(done), 32'h1);
    chk("cipher_flag", 32'(rdv[2]), 32'h1);
    chk("bbram_sel", 32'(key_sel), 32'h0);
    pulse(KRD);
    chk("bbram_word", dec_word, 32'h0);
    req(sec_ctrl_pkg::SRC_X8, 1'b0, 1'b0);
    req(sec_ctrl_pkg::SRC_INTERNAL, 1'b1, 1'b1);
    pulse(RECONF);
    tick(2);
    rd(ST);
    chk("key_kept", 32'(rdv[4]), 32'h1);
    load(32'h40, sec_ctrl_pkg::SRC_X16, 1'b0);
    rd(ST);
    chk("wide_words", 32'(words), 32'h0);
    chk("wide_state", 32'(rdv[10:8]), 32'(sec_ctrl_pkg::ST_FAIL));
    pulse(PROG);
    tick(2);
    wr(CT, 32'h3);
    go(32'h8000_0040, sec_ctrl_pkg::SRC_JTAG);
    tick(5);
    chk("fuse_sel", 32'(key_sel), 32'h1);
    pulse(KRD);
    chk("fuse_word", dec_word, FUSE);
    pulse(MISM);
    tick(2);
    chk("fail_done", 32'(done), 32'h0);
    chk("fail_monitor", 32'(mon_ok), 32'h0);
    chk("fail_fuse_prog", 32'(fuse_ok), 32'h0);
    chk("fail_init", 32'(init_oe), 32'h1);
    chk("fail_init_level", 32'(init), 32'h0);
    tick(80);
    chk("init_held", 32'(init_oe), 32'h1);
    tick(40);
    chk("init_back", 32'(init_oe), 32'h0);
    load(32'h40, sec_ctrl_pkg::SRC_SERIAL, 1'b1);
    chk("relock_done", 32'(done), 32'h1);
    chk("relock_monitor", 32'(mon_ok), 32'h1);
    wr(CT, 32'hb);
    seen = 1'b0;
    repeat (4) begin
      tick(1);
      seen = seen | exp_clr;
    end
    rd(ST);
    chk("erase_pulse", 32'(seen), 32'h1);
    chk("erase_key", 32'(rdv[4]), 32'h0);
    give_verdict();
  end
  initial begin
    tick(3000);
    failures++;
    give_verdict();
  end
endmodule
`default_nettype wire

// ### testbench/cfg_source.sv
`timescale 1ns/100ps
`default_nettype none
module cfg_source (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Frame request
  input wire logic send_in,
  input wire logic [31:0] ctl_in,
  input wire sec_ctrl_pkg::cfg_src_t src_in,
  // Stream
  output sec_ctrl_pkg::cfg_word_t cfg_out,
  output logic busy_out
);
  // ----------------
  // Frame sequencer
  // ----------------
  logic [3:0] cnt_reg;
  logic [31:0] idle_reg;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in)
      cnt_reg <= 4'h0;
    else if (send_in && cnt_reg == 4'h0)
      cnt_reg <= 4'hc;
    else if (cnt_reg != 4'h0)
      cnt_reg <= cnt_reg - 4'h1;
  end
  // Idle data toggles so a stale word never looks held
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in)
      idle_reg <= 32'h0f0f_0f0f;
    else
      idle_reg <= ~idle_reg;
  end
  assign busy_out = (cnt_reg != 4'h0);
  assign cfg_out.valid = busy_out;
  assign cfg_out.control_word_zero = (cnt_reg == 4'hb);
  assign cfg_out.src = src_in;
  assign cfg_out.data = !busy_out ? idle_reg : cfg_out.control_word_zero ? ctl_in : {idle_reg[31:4], cnt_reg};
endmodule
`default_nettype wire

// ### testbench/sec_ctrl_props.sv
`timescale 1ns/100ps
`default_nettype none
module sec_ctrl_props (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Watched inputs
  input wire logic key_load_instruction_in,
  input wire logic mismatch_in,
  input wire sec_ctrl_pkg::cfg_word_t cfg_in,
  input wire logic dec_key_rd_in,
  input wire logic [31:0] fuse_key_word_in,
  input wire logic rb_req_in,
  input wire sec_ctrl_pkg::cfg_src_t rb_src_in,
  // Watched outputs
  input wire sec_ctrl_pkg::load_word_t load_out,
  input wire logic cfg_clear_out,
  input wire logic [31:0] dec_key_word_out,
  input wire logic dec_key_sel_out,
  input wire logic rb_grant_out,
  input wire logic monitor_rb_ok_out,
  input wire logic fuse_prog_ok_out,
  input wire logic done_out,
  input wire logic init_out,
  input wire logic init_oe_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // ----------------
  // Helper state
  // ----------------
  logic enc_seen_reg;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in)
      enc_seen_reg <= 1'b0;
    else if (load_out.valid)
      enc_seen_reg <= load_out.cipher;
  end
  // ----------------
  // Assertions
  // ----------------
  a_key_load_clear: assert property (key_load_instruction_in |-> ##[1:2] cfg_clear_out)
    else $error("key load did not clear memory");
  a_fail_done_low: assert property (mismatch_in |=> !done_out [*3])
    else $error("done high after mismatch");
  a_init_pulse_low: assert property (mismatch_in |-> ##3 (init_oe_out && !init_out) [*8])
    else $error("init not pulsed low after mismatch");
  a_fail_lockout: assert property (mismatch_in |-> ##2
    !(monitor_rb_ok_out || fuse_prog_ok_out || rb_grant_out)) else $error("access open after fail");
  a_bbram_hidden: assert property (dec_key_rd_in && !dec_key_sel_out |=>
    dec_key_word_out == 32'h0) else $error("stored key word visible");
  a_fuse_key_path: assert property (dec_key_rd_in && dec_key_sel_out |=>
    dec_key_word_out == $past(fuse_key_word_in)) else $error("fuse key word wrong");
  a_plain_bypass: assert property (load_out.valid && !load_out.cipher |->
    load_out.data == $past(cfg_in.data)) else $error("plain word altered");
  a_wide_refused: assert property (cfg_in.valid && cfg_in.control_word_zero && cfg_in.data[6] &&
    cfg_in.src inside {sec_ctrl_pkg::SRC_X16, sec_ctrl_pkg::SRC_X32} |=> !load_out.valid)
    else $error("wide encrypted load forwarded");
  a_enc_no_ext_rb: assert property (rb_req_in && rb_src_in != sec_ctrl_pkg::SRC_INTERNAL &&
    enc_seen_reg |-> !rb_grant_out) else $error("external readback after encrypted load");
  a_blk_only_cipher: assert property (load_out.valid && load_out.blk_last |->
    load_out.cipher) else $error("block mark on plain word");
  c_mismatch: cover property (mismatch_in ##[1:3] init_oe_out);
  c_cipher_block: cover property (load_out.valid && load_out.cipher && load_out.blk_last);
  c_rb_grant: cover property (rb_req_in && rb_grant_out);
endmodule
bind sec_ctrl sec_ctrl_props props_i (
  .mclk_in, .rst_in, .key_load_instruction_in, .mismatch_in, .cfg_in, .dec_key_rd_in,
  .fuse_key_word_in, .rb_req_in, .rb_src_in, .load_out, .cfg_clear_out, .dec_key_word_out,
  .dec_key_sel_out, .rb_grant_out, .monitor_rb_ok_out, .fuse_prog_ok_out, .done_out,
  .init_out, .init_oe_out
);
`default_nettype wire

// ### verilog/key_store.sv
`timescale 1ns/100ps
`default_nettype none
module key_store (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Write side
  input wire logic wr_in,
  input wire logic [2:0] widx_in,
  input wire logic [31:0] wdata_in,
  input wire logic clear_in,
  // Read side
  input wire logic rd_in,
  input wire logic [2:0] ridx_in,
  output logic [31:0] rdata_out
);
  logic [31:0] mem_reg [sec_ctrl_pkg::KEY_WORDS];

  // ----------------------------------------
  // Storage, whole clear
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < sec_ctrl_pkg::KEY_WORDS; i++) begin : g_word
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          mem_reg[i] <= 32'h0000_0000;
        end else if (clear_in) begin
          mem_reg[i] <= 32'h0000_0000;
        end else if (wr_in && widx_in == 3'(i)) begin
          mem_reg[i] <= wdata_in;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Registered read
  // ----------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (clear_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (rd_in) begin
      rdata_out <= mem_reg[ridx_in];
    end
  end
endmodule
`default_nettype wire

// ### verilog/sec_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module sec_ctrl (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Resets and reprogram events
  input wire logic program_in,
  input wire logic jtag_reconfig_instruction_in,
  input wire logic internal_reprogram_cmd_in,
  // JTAG key access
  input wire logic key_load_instruction_in,
  input wire logic key_access_exit_in,
  input wire logic jtag_key_wr_in,
  input wire logic [2:0] jtag_key_idx_in,
  input wire logic [31:0] jtag_key_wdata_in,
  // Configuration stream
  input wire sec_ctrl_pkg::cfg_word_t cfg_in,
  input wire logic load_end_in,
  input wire logic mismatch_in,
  output sec_ctrl_pkg::load_word_t load_out,
  output logic cfg_clear_out,
  // Decryptor key port
  input wire logic dec_key_rd_in,
  input wire logic [2:0] dec_key_idx_in,
  input wire logic [31:0] fuse_key_word_in,
  output logic [31:0] dec_key_word_out,
  output logic dec_key_sel_out,
  output logic expkey_clear_out,
  // Access requests
  input wire logic rb_req_in,
  input wire sec_ctrl_pkg::cfg_src_t rb_src_in,
  input wire logic pr_req_in,
  input wire sec_ctrl_pkg::cfg_src_t pr_src_in,
  output logic rb_grant_out,
  output logic pr_grant_out,
  output logic monitor_rb_ok_out,
  output logic fuse_prog_ok_out,
  // Pins
  output logic done_out,
  output logic init_out,
  output logic init_oe_out
);
  sec_ctrl_pkg::cfg_state_t state_reg;
  sec_ctrl_pkg::cfg_state_t state_next;
  logic [31:0] ctrl_reg;
  logic cipher_reg;
  logic key_sel_reg;
  logic key_valid_reg;
  logic fresh_reg;
  logic fail_lock_reg;
  logic enc_done_reg;
  logic [1:0] wcnt_reg;
  logic first_blk_reg;
  logic [7:0] init_cnt_reg;
  logic [31:0] bb_key_word;
  logic fuse_pick_reg;
  logic ext_src;
  logic bad_width;
  logic plain_refused;
  logic reload_evt;
  logic erase_req;
  logic key_clear;
  logic fallback_en;
  sec_ctrl_pkg::sec_level_t level;

  assign fallback_en = ctrl_reg[sec_ctrl_pkg::CTRL_FALLBACK_BIT];
  assign level = sec_ctrl_pkg::sec_level_t'(ctrl_reg[sec_ctrl_pkg::CTRL_LEVEL_LSB +: 2]);
  assign ext_src = cfg_in.src != sec_ctrl_pkg::SRC_INTERNAL;
  assign reload_evt = program_in | jtag_reconfig_instruction_in;

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_reg <= sec_ctrl_pkg::CTRL_RESET;
    end else if (reg_wr_in && reg_addr_in == sec_ctrl_pkg::CTRL_OFFS) begin
      ctrl_reg <= {28'h0000000, 1'b0, reg_wdata_in[2:0]};
    end
  end

  assign erase_req = reg_wr_in && reg_addr_in == sec_ctrl_pkg::CTRL_OFFS
    && reg_wdata_in[sec_ctrl_pkg::CTRL_ERASE_BIT];

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        sec_ctrl_pkg::CTRL_OFFS: reg_rdata_out <= ctrl_reg;
        sec_ctrl_pkg::STATUS_OFFS: reg_rdata_out <= {21'h000000, state_reg, fresh_reg,
          fail_lock_reg, enc_done_reg, key_valid_reg, key_sel_reg, cipher_reg, done_out,
          init_oe_out};
        default: reg_rdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Load admission checks
  // ----------------------------------------
  // width check
  assign bad_width = cfg_in.control_word_zero && cfg_in.data[sec_ctrl_pkg::CONTROL_WORD_ZERO_CIPHER_BIT]
    && (cfg_in.src == sec_ctrl_pkg::SRC_X16 || cfg_in.src == sec_ctrl_pkg::SRC_X32);
  assign plain_refused = cfg_in.control_word_zero && !cfg_in.data[sec_ctrl_pkg::CONTROL_WORD_ZERO_CIPHER_BIT]
    && key_valid_reg && !fresh_reg;

  // ----------------------------------------
  // Configuration state machine
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sec_ctrl_pkg::ST_IDLE: begin
        // fail lock, fallback load still admitted
        if (cfg_in.valid && (!fail_lock_reg || fallback_en)) begin
          state_next = sec_ctrl_pkg::ST_LOAD;
        end
      end
      sec_ctrl_pkg::ST_CLEAR: begin
        state_next = sec_ctrl_pkg::ST_IDLE;
      end
      sec_ctrl_pkg::ST_KEY_ACCESS: begin
        if (key_access_exit_in) begin
          state_next = sec_ctrl_pkg::ST_IDLE;
        end
      end
      sec_ctrl_pkg::ST_LOAD: begin
        if (bad_width || plain_refused || mismatch_in) begin
          state_next = sec_ctrl_pkg::ST_FAIL;
        end else if (load_end_in) begin
          state_next = sec_ctrl_pkg::ST_DONE;
        end
      end
      sec_ctrl_pkg::ST_DONE: begin
        if (internal_reprogram_cmd_in) begin
          state_next = sec_ctrl_pkg::ST_CLEAR;
        end
      end
      sec_ctrl_pkg::ST_FAIL: begin
        if (fallback_en && init_cnt_reg == 8'h00) begin
          state_next = sec_ctrl_pkg::ST_CLEAR;
        end
      end
      default: state_next = sec_ctrl_pkg::ST_IDLE;
    endcase
    if (reload_evt) begin
      state_next = sec_ctrl_pkg::ST_CLEAR;
    end
    if (key_load_instruction_in) begin
      state_next = sec_ctrl_pkg::ST_KEY_ACCESS;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= sec_ctrl_pkg::ST_CLEAR;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_clear_out <= 1'b1;
    end else begin
      cfg_clear_out <= state_next == sec_ctrl_pkg::ST_CLEAR
        || (key_load_instruction_in && state_reg != sec_ctrl_pkg::ST_KEY_ACCESS);
    end
  end

  // ----------------------------------------
  // Control word zero flags
  // ----------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cipher_reg <= 1'b0;
      key_sel_reg <= 1'b0;
    end else if (state_next == sec_ctrl_pkg::ST_CLEAR) begin
      cipher_reg <= 1'b0;
      key_sel_reg <= 1'b0;
    end else if (state_reg == sec_ctrl_pkg::ST_LOAD && cfg_in.valid && cfg_in.control_word_zero) begin
      cipher_reg <= cfg_in.data[sec_ctrl_pkg::CONTROL_WORD_ZERO_CIPHER_BIT];
      key_sel_reg <= cfg_in.data[sec_ctrl_pkg::CONTROL_WORD_ZERO_KEYSEL_BIT];
    end
  end

  // ----------------------------------------
  // Memory freshness and lock flags
  // ----------------------------------------
  // fresh after reset
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fresh_reg <= 1'b1;
    end else if (reload_evt || key_load_instruction_in) begin
      fresh_reg <= 1'b1;
    end else if (state_reg == sec_ctrl_pkg::ST_DONE) begin
      fresh_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fail_lock_reg <= 1'b0;
    end else if (state_reg == sec_ctrl_pkg::ST_LOAD && state_next == sec_ctrl_pkg::ST_FAIL
                 && cipher_reg) begin
      fail_lock_reg <= 1'b1;
    end else if (state_next == sec_ctrl_pkg::ST_DONE) begin
      fail_lock_reg <= 1'b0;
    end else if (reload_evt && !fallback_en) begin
      fail_lock_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      enc_done_reg <= 1'b0;
    end else if (state_next == sec_ctrl_pkg::ST_DONE && state_reg == sec_ctrl_pkg::ST_LOAD) begin
      enc_done_reg <= cipher_reg;
    end else if (reload_evt || key_load_instruction_in) begin
      enc_done_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Key storage
  // ----------------------------------------
  // erase after encrypted
  assign key_clear = (key_load_instruction_in && state_reg != sec_ctrl_pkg::ST_KEY_ACCESS)
    || (erase_req && enc_done_reg);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      key_valid_reg <= 1'b0;
    end else if (key_clear) begin
      key_valid_reg <= 1'b0;
    end else if (state_reg == sec_ctrl_pkg::ST_KEY_ACCESS && jtag_key_wr_in) begin
      key_valid_reg <= 1'b1;
    end
  end

  key_store u_key_store (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .wr_in(state_reg == sec_ctrl_pkg::ST_KEY_ACCESS && jtag_key_wr_in),
    .widx_in(jtag_key_idx_in),
    .wdata_in(jtag_key_wdata_in),
    .clear_in(key_clear),
    .rd_in(dec_key_rd_in && state_reg == sec_ctrl_pkg::ST_LOAD),
    .ridx_in(dec_key_idx_in),
    .rdata_out(bb_key_word)
  );

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      expkey_clear_out <= 1'b0;
    end else begin
      expkey_clear_out <= key_clear;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fuse_pick_reg <= 1'b0;
    end else if (dec_key_rd_in && state_reg == sec_ctrl_pkg::ST_LOAD) begin
      fuse_pick_reg <= key_sel_reg;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      dec_key_word_out <= 32'h0000_0000;
    end else if (dec_key_rd_in && state_reg == sec_ctrl_pkg::ST_LOAD && key_sel_reg) begin
      dec_key_word_out <= fuse_key_word_in;
    end else if (!cipher_reg || state_reg != sec_ctrl_pkg::ST_LOAD) begin
      dec_key_word_out <= 32'h0000_0000;
    end
  end

  assign dec_key_sel_out = key_sel_reg;

  // ----------------------------------------
  // Word stream to loader or decryptor
  // ----------------------------------------
  // vector first block
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wcnt_reg <= 2'b00;
      first_blk_reg <= 1'b1;
    end else if (state_reg != sec_ctrl_pkg::ST_LOAD || !cipher_reg) begin
      wcnt_reg <= 2'b00;
      first_blk_reg <= 1'b1;
    end else if (cfg_in.valid && !cfg_in.control_word_zero) begin
      wcnt_reg <= wcnt_reg + 2'b01;
      if (wcnt_reg == 2'(sec_ctrl_pkg::BLK_WORDS - 1)) begin
        first_blk_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      load_out <= '0;
    end else begin
      load_out.valid <= state_reg == sec_ctrl_pkg::ST_LOAD && cfg_in.valid && !bad_width
        && !plain_refused;
      load_out.data <= cfg_in.data;
      load_out.cipher <= cipher_reg && !cfg_in.control_word_zero;
      load_out.blk_last <= cipher_reg && wcnt_reg == 2'(sec_ctrl_pkg::BLK_WORDS - 1);
      load_out.iv <= cipher_reg && first_blk_reg && !cfg_in.control_word_zero;
    end
  end

  // ----------------------------------------
  // Readback and partial reload grants
  // ----------------------------------------
  always_comb begin
    rb_grant_out = 1'b0;
    if (rb_req_in && state_reg == sec_ctrl_pkg::ST_DONE && !fail_lock_reg) begin
      if (rb_src_in == sec_ctrl_pkg::SRC_INTERNAL) begin
        rb_grant_out = 1'b1;
      end else if (enc_done_reg) begin
        rb_grant_out = 1'b0;
      end else begin
        rb_grant_out = level == sec_ctrl_pkg::LVL_NONE || level == sec_ctrl_pkg::LVL_ONE;
      end
    end
  end

  always_comb begin
    pr_grant_out = 1'b0;
    if (pr_req_in && state_reg == sec_ctrl_pkg::ST_DONE && !fail_lock_reg) begin
      if (pr_src_in == sec_ctrl_pkg::SRC_INTERNAL) begin
        pr_grant_out = 1'b1;
      end else begin
        pr_grant_out = (level == sec_ctrl_pkg::LVL_NONE || level == sec_ctrl_pkg::LVL_ONE)
          && !enc_done_reg;
      end
    end
  end

  assign monitor_rb_ok_out = !fail_lock_reg;
  assign fuse_prog_ok_out = !fail_lock_reg && state_reg != sec_ctrl_pkg::ST_LOAD;

  // ----------------------------------------
  // Done and init pins
  // ----------------------------------------
  // done stays low outside ST_DONE
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= state_next == sec_ctrl_pkg::ST_DONE;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      init_cnt_reg <= 8'h00;
    end else if (state_reg == sec_ctrl_pkg::ST_LOAD && state_next == sec_ctrl_pkg::ST_FAIL) begin
      init_cnt_reg <= 8'(sec_ctrl_pkg::INIT_PULSE_CYC - 1);
    end else if (init_cnt_reg != 8'h00) begin
      init_cnt_reg <= init_cnt_reg - 8'h01;
    end
  end

  assign init_out = 1'b0;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      init_oe_out <= 1'b1;
    end else begin
      init_oe_out <= state_next == sec_ctrl_pkg::ST_CLEAR || state_next == sec_ctrl_pkg::ST_FAIL;
    end
  end

  logic unused_ok;
  assign unused_ok = ext_src | fuse_pick_reg | (|bb_key_word);
endmodule
`default_nettype wire

// ### verilog/sec_ctrl_pkg.sv
package sec_ctrl_pkg;
  // ----------------------------------------
  // Sizes and timing
  // ----------------------------------------
  localparam int KEY_WORDS = 8;
  localparam int BLK_WORDS = 4;
  localparam int CLK_PERIOD_NS = 8;
  localparam int INIT_PULSE_NS = 800;
  localparam int INIT_PULSE_CYC = (INIT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONTROL_WORD_ZERO_CIPHER_BIT = 6;
  localparam int CONTROL_WORD_ZERO_KEYSEL_BIT = 31;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] CTRL_OFFS = 4'h0;
  localparam logic [3:0] STATUS_OFFS = 4'h4;
  localparam int CTRL_FALLBACK_BIT = 0;
  localparam int CTRL_LEVEL_LSB = 1;
  localparam int CTRL_ERASE_BIT = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  typedef enum logic [2:0] {
    SRC_SERIAL = 3'b000,
    SRC_JTAG = 3'b001,
    SRC_X8 = 3'b010,
    SRC_X16 = 3'b011,
    SRC_X32 = 3'b100,
    SRC_INTERNAL = 3'b101
  } cfg_src_t;
  typedef enum logic [1:0] {
    LVL_NONE = 2'b00,
    LVL_ONE = 2'b01,
    LVL_TWO = 2'b10,
    LVL_ALL = 2'b11
  } sec_level_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CLEAR = 3'b001,
    ST_KEY_ACCESS = 3'b010,
    ST_LOAD = 3'b011,
    ST_DONE = 3'b100,
    ST_FAIL = 3'b101
  } cfg_state_t;
  typedef struct packed {
    logic [31:0] data;
    cfg_src_t src;
    logic control_word_zero;
    logic valid;
  } cfg_word_t;
  typedef struct packed {
    logic [31:0] data;
    logic iv;
    logic blk_last;
    logic cipher;
    logic valid;
  } load_word_t;
endpackage
